/* tcc_pkg.sv */
// constants and types for the four-channel capture/compare timer
// assumes an apb master on the same clock as the timer logic
package tcc_pkg;

  // register word indices; byte address is index times four
  localparam logic [5:0] IDX_STATUS = 6'h00;
  localparam logic [5:0] IDX_CNT_HI = 6'h01;
  localparam logic [5:0] IDX_CNT_LO = 6'h02;
  localparam logic [5:0] IDX_MOD_HI = 6'h03;
  localparam logic [5:0] IDX_MOD_LO = 6'h04;
  localparam logic [5:0] IDX_CTL0 = 6'h05;
  localparam logic [5:0] IDX_VAL0_HI = 6'h09;
  // first unmapped index; channel 3 value low sits at index 16
  localparam logic [5:0] IDX_LAST = 6'h11;

  // timer_status_control bit positions
  localparam int ST_FLAG = 7;
  localparam int ST_IRQ_EN = 6;
  localparam int ST_STOP = 5;
  localparam int ST_RESET = 4;
  localparam int ST_PS_LSB = 0;

  localparam logic [2:0] PS_EXTERNAL = 3'h7;
  localparam logic [15:0] MOD_RESET = 16'hffff;
  localparam logic [6:0] PRESC_RESET = 7'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;

  // edge/level codes
  localparam logic [1:0] ELS_OFF = 2'h0;
  localparam logic [1:0] ELS_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_CLEAR = 2'h2;
  localparam logic [1:0] ELS_SET = 2'h3;

  // channel_control layout, msb first
  typedef struct packed {
    logic flag;
    logic irq_en;
    logic buf_mode;
    logic unbuf_mode;
    logic [1:0] els;
    logic tov;
    logic max_duty;
  } tcc_ctl_t;

  localparam tcc_ctl_t CTL_RESET = 8'h00;

  // apb request as seen by the slave
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } tcc_apb_req_t;

endpackage

/* tcc_timer.sv */
// four-channel 16-bit capture/compare timer with an apb register slave
// assumes apb master on CLK_SYS; pins and external clock are asynchronous
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - set overflow flag when counter wraps to zero after reaching modulo
// - clear overflow flag by read-then-write-zero; new overflow cancels
// - overflow interrupt while flag and its enable are both set
// - stop bit halts counter; reset value is stopped
// - counter reset bit clears counter and prescaler, reads as zero
// - stop plus counter reset in one write leaves counter held at zero
// - clock select picks bus clock divided 1..64 or external pin
// - high-byte counter read latches low byte until low byte read
// - counter registers read-only, cleared by reset and counter reset
// - on equal to modulo, flag sets and counting restarts from zero
// - modulo high write blocks overflow flag until low byte written
// - channel flag on active capture edge or compare match
// - channel flag cleared by read-then-write-zero; new event cancels
// - channel interrupt while channel flag and enable both set
// - buffered bit on channels 0 and 2 disables partner and its pin
// - unbuffered bit picks capture/compare, or preset level when off
// - edge/level code selects edges or toggle/clear/set on match
// - toggle on overflow in compare; overflow beats match
// - max duty forces full duty on clear/set without toggle on overflow, from next period
// - capture high-byte read blocks captures until low byte read
// - compare high-byte write blocks matches until low byte written
// - buffered pwm switches source at overflow to last written pair
// - without toggle on overflow and max duty, pwm gives zero duty
module tcc_timer
  import tcc_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // pins
  input wire logic EXT_CLK,
  input wire logic [3:0] CH_IN,
  output logic [3:0] CH_OUT,
  output logic [3:0] CH_OE,
  // interrupt requests
  output logic OVF_IRQ,
  output logic [3:0] CH_IRQ
);

  // capture mode: both mode bits clear and an edge selected
  function automatic logic fn_cap(input tcc_ctl_t c);
    fn_cap = !c.buf_mode && !c.unbuf_mode && (c.els != ELS_OFF);
  endfunction

  // compare mode: either mode bit set and an action selected
  function automatic logic fn_cmp(input tcc_ctl_t c);
    fn_cmp = (c.buf_mode || c.unbuf_mode) && (c.els != ELS_OFF);
  endfunction

  tcc_apb_req_t req;
  assign req = '{PSEL, PENABLE, PWRITE, PADDR, PWDATA};

  // registers
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic ovf_flag_q, ovf_arm_q, ovf_ie_q, stop_q;
  logic [2:0] ps_q;
  logic [15:0] cnt_q, mod_q;
  logic [6:0] presc_q;
  logic [7:0] cnt_lat_q;
  logic cnt_lat_valid_q;
  logic [7:0] cnt_snap_q;
  logic mod_hold_q;
  tcc_ctl_t ctl_q [4];
  logic [15:0] val_q [4];
  logic [3:0] ch_arm_q, cap_hold_q, cmp_hold_q, max_eff_q;
  logic [3:0] out_q, oe_q, ch_irq_q;
  logic ovf_irq_q;
  logic [1:0] last_q, sel_q;
  logic [3:0] ch_s1_q, ch_s2_q, ch_s3_q;
  logic ext_s1_q, ext_s2_q, ext_s3_q;

  // bus decode; side effects happen only at the completing edge
  logic acc, wr_en, rd_en, mapped;
  logic [5:0] idx;
  logic [7:0] wd;
  logic setup;
  assign setup = req.sel && !req.enable;
  assign acc = req.sel && req.enable && pready_q;
  // refused transfers have no side effects at all
  assign wr_en = acc && req.write && mapped;
  assign rd_en = acc && !req.write && mapped;
  assign idx = req.addr[7:2];
  assign wd = req.wdata[7:0];
  assign mapped = (idx < IDX_LAST) && (req.addr[1:0] == 2'h0);

  logic wr_st, wr_modh, wr_modl, rd_st, rd_cnth, rd_cntl;
  assign wr_st = wr_en && idx == IDX_STATUS;
  assign wr_modh = wr_en && idx == IDX_MOD_HI;
  assign wr_modl = wr_en && idx == IDX_MOD_LO;
  assign rd_st = rd_en && idx == IDX_STATUS;
  assign rd_cnth = rd_en && idx == IDX_CNT_HI;
  assign rd_cntl = rd_en && idx == IDX_CNT_LO;

  // counter clock; prescaler taps compare low bits against all ones
  logic [6:0] ps_mask;
  logic ext_rise, tick, roll, ovf_ev, cnt_clr;
  assign ps_mask = 7'((8'h01 << ps_q) - 8'h01);
  assign ext_rise = ext_s2_q && !ext_s3_q;
  assign tick = !stop_q && ((ps_q == PS_EXTERNAL) ? ext_rise :
                ((presc_q & ps_mask) == ps_mask));
  assign roll = tick && (cnt_q == mod_q);
  assign ovf_ev = roll && !mod_hold_q;
  assign cnt_clr = wr_st && wd[ST_RESET];

  logic [15:0] cnt_nx;
  assign cnt_nx = roll ? CNT_RESET : 16'(cnt_q + 16'h0001);

  // per-channel events and pin targets
  logic [3:0] dis, cap_m, cmp_m, edge_ev, cap_ev, cmp_ev, ch_ev;
  logic [3:0] wr_ctl, rd_ctl, wr_vh, wr_vl, rd_vh, rd_vl;
  logic [15:0] cmp_val [4];
  genvar g;
  for (g = 0; g < 4; g++) begin : g_ch
    localparam int LEAD = g - (g % 2);
    logic rise, fall;
    assign dis[g] = (g % 2 == 1) && ctl_q[LEAD].buf_mode;
    assign cap_m[g] = fn_cap(ctl_q[g]) && !dis[g];
    assign cmp_m[g] = fn_cmp(ctl_q[g]) && !dis[g];
    assign rise = ch_s2_q[g] && !ch_s3_q[g];
    assign fall = !ch_s2_q[g] && ch_s3_q[g];
    // edge selection
    assign edge_ev[g] = (ctl_q[g].els[0] && rise) ||
                        (ctl_q[g].els[1] && fall);
    assign cap_ev[g] = cap_m[g] && edge_ev[g] && !cap_hold_q[g];
    // buffered leaders take the last-chosen pair register
    assign cmp_val[g] = (ctl_q[g].buf_mode && sel_q[g/2]) ?
                        val_q[g+1-(g%2)] : val_q[g];
    assign cmp_ev[g] = cmp_m[g] && tick && !cmp_hold_q[g] &&
                       (cnt_nx == cmp_val[g]);
    assign ch_ev[g] = cap_ev[g] || cmp_ev[g];
    assign wr_ctl[g] = wr_en && idx == 6'(IDX_CTL0 + g) && !dis[g];
    assign rd_ctl[g] = rd_en && idx == 6'(IDX_CTL0 + g);
    assign wr_vh[g] = wr_en && idx == 6'(IDX_VAL0_HI + 2 * g);
    assign wr_vl[g] = wr_en && idx == 6'(IDX_VAL0_HI + 2 * g + 1);
    assign rd_vh[g] = rd_en && idx == 6'(IDX_VAL0_HI + 2 * g);
    assign rd_vl[g] = rd_en && idx == 6'(IDX_VAL0_HI + 2 * g + 1);
  end

  // read mux, sampled in the setup phase
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (idx == IDX_STATUS) begin
      rd_mux = {ovf_flag_q, ovf_ie_q, stop_q, 1'b0, 1'b0, ps_q};
    end else if (idx == IDX_CNT_HI) begin
      rd_mux = cnt_q[15:8];
    end else if (idx == IDX_CNT_LO) begin
      rd_mux = cnt_lat_valid_q ? cnt_lat_q : cnt_q[7:0];
    end else if (idx == IDX_MOD_HI) begin
      rd_mux = mod_q[15:8];
    end else if (idx == IDX_MOD_LO) begin
      rd_mux = mod_q[7:0];
    end else if (idx >= IDX_CTL0 && idx < IDX_VAL0_HI) begin
      rd_mux = ctl_q[2'(idx - IDX_CTL0)];
    end else if (idx >= IDX_VAL0_HI && idx < IDX_LAST) begin
      rd_mux = idx[0] ? val_q[2'((idx - IDX_VAL0_HI) >> 1)][15:8] :
                        val_q[2'((idx - IDX_VAL0_HI) >> 1)][7:0];
    end
  end

  // apb handshake: one wait-free access phase after every setup
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      cnt_snap_q <= 8'h00;
    end else begin
      pready_q <= setup;
      if (setup) begin
        cnt_snap_q <= cnt_q[7:0];
        prdata_q <= {24'h00_0000, mapped ? rd_mux : 8'h00};
        pslverr_q <= !mapped;
      end
    end
  end

  // synchronisers; only the second and third stages feed edge logic
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      {ch_s1_q, ch_s2_q, ch_s3_q} <= 12'h000;
      {ext_s1_q, ext_s2_q, ext_s3_q} <= 3'h0;
    end else begin
      {ch_s1_q, ch_s2_q, ch_s3_q} <= {CH_IN, ch_s1_q, ch_s2_q};
      {ext_s1_q, ext_s2_q, ext_s3_q} <= {EXT_CLK, ext_s1_q, ext_s2_q};
    end
  end

  // status register, prescaler and counter
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ovf_flag_q <= 1'b0;
      ovf_arm_q <= 1'b0;
      ovf_ie_q <= 1'b0;
      stop_q <= 1'b1;
      ps_q <= 3'h0;
      presc_q <= PRESC_RESET;
      cnt_q <= CNT_RESET;
      mod_q <= MOD_RESET;
      mod_hold_q <= 1'b0;
      ovf_irq_q <= 1'b0;
    end else begin
      if (wr_st) begin
        ovf_ie_q <= wd[ST_IRQ_EN];
        stop_q <= wd[ST_STOP];
        ps_q <= wd[ST_PS_LSB +: 3];
      end
      // set beats clear, and an overflow disarms a pending clear
      if (ovf_ev) begin
        ovf_flag_q <= 1'b1;
        ovf_arm_q <= 1'b0;
      end else if (wr_st && !wd[ST_FLAG] && ovf_arm_q) begin
        ovf_flag_q <= 1'b0;
        ovf_arm_q <= 1'b0;
      end else if (rd_st && ovf_flag_q) begin
        ovf_arm_q <= 1'b1;
      end
      // counter reset wins over counting, also when stopped
      if (cnt_clr) begin
        presc_q <= PRESC_RESET;
        cnt_q <= CNT_RESET;
      end else if (!stop_q) begin
        presc_q <= 7'(presc_q + 7'h01);
        if (tick) begin
          cnt_q <= cnt_nx;
        end
      end
      if (wr_modh) begin
        mod_q[15:8] <= wd;
        mod_hold_q <= 1'b1;
      end else if (wr_modl) begin
        mod_q[7:0] <= wd;
        mod_hold_q <= 1'b0;
      end
      ovf_irq_q <= ovf_flag_q && ovf_ie_q;
    end
  end

  // counter low-byte latch; a second high read keeps the first value
  // low byte comes from the setup edge, same as the high byte, so a
  // carry between setup and access cannot tear the 16-bit value
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt_lat_q <= 8'h00;
      cnt_lat_valid_q <= 1'b0;
    end else if (rd_cnth && !cnt_lat_valid_q) begin
      cnt_lat_q <= cnt_snap_q;
      cnt_lat_valid_q <= 1'b1;
    end else if (rd_cntl) begin
      cnt_lat_valid_q <= 1'b0;
    end
  end

  // channel value registers have no reset
  always_ff @(posedge CLK_SYS) begin
    for (int i = 0; i < 4; i++) begin
      if (cap_ev[i]) begin
        val_q[i] <= cnt_q;
      end else if (wr_vh[i]) begin
        val_q[i][15:8] <= wd;
      end else if (wr_vl[i]) begin
        val_q[i][7:0] <= wd;
      end
    end
  end

  // channel control, flags, holds and buffered source selection
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < 4; i++) begin
        ctl_q[i] <= CTL_RESET;
      end
      ch_arm_q <= 4'h0;
      cap_hold_q <= 4'h0;
      cmp_hold_q <= 4'h0;
      max_eff_q <= 4'h0;
      last_q <= 2'h0;
      sel_q <= 2'h0;
      ch_irq_q <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr_ctl[i]) begin
          ctl_q[i].irq_en <= wd[6];
          // only the pair leaders hold the buffered bit
          ctl_q[i].buf_mode <= (i % 2 == 0) ? wd[5] : 1'b0;
          ctl_q[i].unbuf_mode <= wd[4];
          ctl_q[i].els <= wd[3:2];
          ctl_q[i].tov <= wd[1];
          ctl_q[i].max_duty <= wd[0];
        end
        // event sets and disarms; clear needs an armed zero write
        if (ch_ev[i]) begin
          ctl_q[i].flag <= 1'b1;
          ch_arm_q[i] <= 1'b0;
        end else if (wr_ctl[i] && !wd[7] && ch_arm_q[i]) begin
          ctl_q[i].flag <= 1'b0;
          ch_arm_q[i] <= 1'b0;
        end else if (rd_ctl[i] && ctl_q[i].flag) begin
          ch_arm_q[i] <= 1'b1;
        end
        if (rd_vh[i] && cap_m[i]) begin
          cap_hold_q[i] <= 1'b1;
        end else if (rd_vl[i]) begin
          cap_hold_q[i] <= 1'b0;
        end
        if (wr_vh[i] && fn_cmp(ctl_q[i])) begin
          cmp_hold_q[i] <= 1'b1;
        end else if (wr_vl[i]) begin
          cmp_hold_q[i] <= 1'b0;
        end
        // max duty is only sampled at a period boundary
        if (roll) begin
          max_eff_q[i] <= ctl_q[i].max_duty;
        end
        ch_irq_q[i] <= ctl_q[i].flag && ctl_q[i].irq_en;
      end
      for (int p = 0; p < 2; p++) begin
        // a completed low-byte write marks the pair member as newest
        if (wr_vl[2 * p] || wr_vl[2 * p + 1]) begin
          last_q[p] <= wr_vl[2 * p + 1];
        end
        if (!ctl_q[2 * p].buf_mode) begin
          sel_q[p] <= 1'b0;
        end else if (roll) begin
          sel_q[p] <= last_q[p];
        end
      end
    end
  end

  // pin drivers; compares to the level already held do nothing
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      out_q <= 4'h0;
      oe_q <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        oe_q[i] <= cmp_m[i];
        if (ctl_q[i].els == ELS_OFF) begin
          out_q[i] <= !ctl_q[i].unbuf_mode;
        end else if (cmp_m[i]) begin
          if (roll && ctl_q[i].tov) begin
            out_q[i] <= !out_q[i];
          end else if (max_eff_q[i] && !ctl_q[i].tov &&
                       ctl_q[i].els != ELS_TOGGLE) begin
            out_q[i] <= (ctl_q[i].els == ELS_CLEAR);
          end else if (cmp_ev[i]) begin
            case (ctl_q[i].els)
              ELS_TOGGLE: out_q[i] <= !out_q[i];
              ELS_CLEAR: out_q[i] <= 1'b0;
              ELS_SET: out_q[i] <= 1'b1;
              default: out_q[i] <= out_q[i];
            endcase
          end
        end
      end
    end
  end

  // outputs straight from flops
  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign CH_OUT = out_q;
  assign CH_OE = oe_q;
  assign OVF_IRQ = ovf_irq_q;
  assign CH_IRQ = ch_irq_q;

endmodule

`default_nettype wire

/* tcc_timer_sva.sv */
// checker for tcc_timer: apb answer timing, refusals, irq and pin gating
// assumes it is bound to tcc_timer and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module tcc_timer_sva
  import tcc_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // pins and requests
  input wire logic EXT_CLK,
  input wire logic [3:0] CH_IN,
  input wire logic [3:0] CH_OUT,
  input wire logic [3:0] CH_OE,
  input wire logic OVF_IRQ,
  input wire logic [3:0] CH_IRQ
);
  logic wr_ok;
  logic is_ctl;
  logic locked;
  logic [1:0] ch_sel;
  logic ovf_ie_q;
  logic [3:0] ch_ie_q;
  logic [3:0] els_on_q;
  logic [1:0] buf_q;
  // a write lands only at an error-free access edge
  assign wr_ok = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
  assign is_ctl = PADDR[7:2] >= IDX_CTL0 && PADDR[7:2] < IDX_VAL0_HI;
  assign ch_sel = PADDR[3:2] - 2'h1;
  assign locked = ch_sel[0] && buf_q[ch_sel[1]];
  // mirror of enables; partner writes are skipped while the pair is linked
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ovf_ie_q <= 1'b0;
      ch_ie_q <= 4'h0;
      els_on_q <= 4'h0;
      buf_q <= 2'h0;
    end else if (wr_ok && PADDR[7:2] == IDX_STATUS) begin
      ovf_ie_q <= PWDATA[ST_IRQ_EN];
    end else if (wr_ok && is_ctl && !locked) begin
      ch_ie_q[ch_sel] <= PWDATA[6];
      els_on_q[ch_sel] <= PWDATA[3:2] != ELS_OFF;
      if (!ch_sel[0]) buf_q[ch_sel[1]] <= PWDATA[5];
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  sequence bad_setup_s;
    setup_s ##0 (PADDR[1:0] != 2'h0 || PADDR[7:2] >= IDX_LAST);
  endsequence
  // the slave answers in the cycle right after every setup
  ready_next_a: assert property (setup_s |=> PREADY)
    else $error("pready missing after setup");
  ready_only_a: assert property (PREADY |-> $past(PSEL && !PENABLE))
    else $error("pready outside first access cycle");
  bad_addr_a: assert property (bad_setup_s |=> PSLVERR && PRDATA == 32'h0)
    else $error("bad address not refused");
  good_addr_a: assert property (setup_s ##0 !PADDR[1:0] && PADDR[7:2] <
    IDX_LAST |=> !PSLVERR) else $error("good address refused");
  rdata_upper_a: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
    else $error("upper read data not zero");
  rst_bit_zero_a: assert property (setup_s ##0 !PWRITE && PADDR == 8'h00
    |=> PRDATA[ST_RESET] == 1'b0) else $error("counter reset bit read 1");
  // irq lines are registered, so one cycle of slack after an enable write
  ovf_irq_gate_a: assert property (OVF_IRQ |-> ovf_ie_q || $past(ovf_ie_q))
    else $error("overflow irq while disabled");
  ch_irq_gate_a: assert property ((CH_IRQ & ~(ch_ie_q | $past(ch_ie_q)))
    == 4'h0) else $error("channel irq while disabled");
  pin_detach_a: assert property ((CH_OE & ~(els_on_q | $past(els_on_q)))
    == 4'h0) else $error("pin driven while detached");
endmodule
bind tcc_timer tcc_timer_sva u_sva (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .EXT_CLK(EXT_CLK), .CH_IN(CH_IN), .CH_OUT(CH_OUT), .CH_OE(CH_OE),
  .OVF_IRQ(OVF_IRQ), .CH_IRQ(CH_IRQ));
`default_nettype wire

/* tb_tcc_timer.sv */
// self-checking bench for tcc_timer over apb, random compare and edges
// assumes the checker file is compiled with it for its bind
`timescale 1ns/1ps
`default_nettype none
module tb_tcc_timer;
  import tcc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ovf_irq;
  logic ext_clk = 1'b0;
  logic [3:0] ch_in = 4'h0;
  logic [3:0] ch_out;
  logic [3:0] ch_oe;
  logic [3:0] ch_irq;
  logic [7:0] r;
  logic e;
  logic hit;
  logic [15:0] v;
  logic [15:0] c0;
  logic [7:0] cv;
  logic [1:0] els_t [3] = '{ELS_SET, ELS_CLEAR, ELS_TOGGLE};
  logic out_t [3] = '{1'b1, 1'b0, 1'b1};
  logic [7:0] bad_t [3] = '{8'h44, 8'h01, 8'hfc};
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  tcc_timer dut (.CLK_SYS(clk), .ARST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EXT_CLK(ext_clk), .CH_IN(ch_in), .CH_OUT(ch_out), .CH_OE(ch_oe),
    .OVF_IRQ(ovf_irq), .CH_IRQ(ch_irq));
  // 200 mhz system clock
  always #2.5 clk = ~clk;
  // hang guard, far above the few thousand cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] ex,
                     input logic [15:0] got);
    check_count++;
    if (got !== ex) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, ex, got);
    end
  endtask
  // window compare where the exact tick phase is left open
  task automatic chk_in(input string what, input int lo, input int hi,
                        input logic [15:0] got);
    check_count++;
    if ($isunknown(got) || got < lo || got > hi) begin
      n_errors++;
      $display("unexpected %s: expected %0d..%0d seen %h", what, lo, hi,
               got);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    apb(1'b1, {i, 2'b00}, d);
  endtask
  task automatic rd(input logic [5:0] i);
    apb(1'b0, {i, 2'b00}, 8'h00);
  endtask
  // 16-bit values go high byte first
  task automatic rd16(input logic [5:0] i);
    rd(i);
    v[15:8] = r;
    rd(i + 6'h1);
    v[7:0] = r;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  initial begin
    void'($urandom(32'h8391));
    tick(3);
    rst_n <= 1'b1;
    rd(IDX_STATUS);
    chk("status", 16'h20, 16'(r));
    rd16(IDX_MOD_HI);
    chk("modulo", MOD_RESET, v);
    for (int i = 0; i < 4; i++) begin
      rd(IDX_CTL0 + 6'(i));
      chk("control", 16'h0, 16'(r));
    end
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, bad_t[i], 8'h00);
      chk("refused", 16'h100, {7'h0, e, r});
    end
    wr(IDX_CNT_LO, 8'h5a);
    rd16(IDX_CNT_HI);
    chk("counter", CNT_RESET, v);
    // every bus divider, then the external pin
    for (int ps = 0; ps < 7; ps++) begin
      wr(IDX_STATUS, 8'h30);
      rd(IDX_STATUS);
      chk("status", 16'h20, 16'(r));
      wr(IDX_STATUS, 8'(ps));
      tick(256);
      wr(IDX_STATUS, 8'h20 | 8'(ps));
      rd16(IDX_CNT_HI);
      chk_in("count", 256 >> ps, (264 >> ps) + 1, v);
      c0 = v;
      tick(20);
      rd16(IDX_CNT_HI);
      chk("held", c0, v);
      wr(IDX_STATUS, 8'h30);
      rd16(IDX_CNT_HI);
      chk("zeroed", CNT_RESET, v);
    end
    wr(IDX_STATUS, {5'h0, PS_EXTERNAL});
    repeat (20) begin
      tick(4);
      ext_clk <= ~ext_clk;
    end
    tick(10);
    wr(IDX_STATUS, 8'h27);
    rd16(IDX_CNT_HI);
    chk("ext count", 16'd10, v);
    // high-byte read freezes the low byte until it is read
    wr(IDX_STATUS, 8'h30);
    wr(IDX_STATUS, 8'h00);
    rd(IDX_CNT_HI);
    c0[15:8] = r;
    tick(300);
    rd(IDX_CNT_LO);
    c0[7:0] = r;
    rd16(IDX_CNT_HI);
    chk_in("latched", 300, 320, v - c0);
    // compare actions on channel 1 with a random match value
    wr(IDX_STATUS, 8'h30);
    wr(IDX_MOD_HI, 8'h00);
    wr(IDX_MOD_LO, 8'd200);
    cv = 8'd40 + 8'($urandom % 100);
    wr(IDX_VAL0_HI + 6'h2, 8'h00);
    wr(IDX_VAL0_HI + 6'h3, cv);
    for (int k = 0; k < 3; k++) begin
      wr(IDX_STATUS, 8'h30);
      wr(IDX_CTL0 + 6'h1, 8'h50 | {4'h0, els_t[k], 2'h0});
      wr(IDX_STATUS, 8'h40);
      tick(150);
      chk("pin", 16'(out_t[k]), 16'(ch_out[1]));
      chk("pin drive", 16'h1, 16'(ch_oe[1]));
      chk("chan irq", 16'h1, 16'(ch_irq[1]));
      chk("ovf irq", 16'h0, 16'(ovf_irq));
    end
    tick(100);
    rd16(IDX_CNT_HI);
    chk_in("wrapped", 40, 70, v);
    wr(IDX_STATUS, 8'h40);
    rd(IDX_STATUS);
    chk("status", 16'hc0, 16'(r));
    chk("ovf irq", 16'h1, 16'(ovf_irq));
    wr(IDX_STATUS, 8'h60);
    rd(IDX_STATUS);
    chk("status", 16'h60, 16'(r));
    chk("ovf irq", 16'h0, 16'(ovf_irq));
    wr(IDX_CTL0 + 6'h1, 8'h50);
    tick(2);
    chk("pin drive", 16'h0, 16'(ch_oe[1]));
    chk("preset", 16'h0, 16'(ch_out[1]));
    // toggle on overflow undoes the set-on-match level at the wrap
    wr(IDX_STATUS, 8'h30);
    wr(IDX_CTL0 + 6'h1, 8'h5e);
    wr(IDX_STATUS, 8'h00);
    tick(150);
    chk("pin set", 16'h1, 16'(ch_out[1]));
    tick(70);
    chk("pin wrap", 16'h0, 16'(ch_out[1]));
    // capture edges on channel 0 for each edge code
    wr(IDX_MOD_HI, 8'hff);
    wr(IDX_MOD_LO, 8'hff);
    wr(IDX_STATUS, 8'h00);
    for (int el = 1; el < 4; el++) begin
      for (int k = 0; k < 2; k++) begin
        wr(IDX_CTL0, 8'h40);
        ch_in[0] <= k[0];
        tick(6);
        wr(IDX_CTL0, 8'h40 | 8'(el << 2));
        rd(IDX_CTL0);
        wr(IDX_CTL0, 8'h40 | 8'(el << 2));
        rd16(IDX_CNT_HI);
        c0 = v;
        tick($urandom % 8);
        ch_in[0] <= ~k[0];
        tick(8);
        hit = el == 3 || el == k + 1;
        rd(IDX_CTL0);
        chk("capture flag", 16'(hit), 16'(r[7]));
        chk("chan irq", 16'(hit), 16'(ch_irq[0]));
        if (hit) begin
          rd16(IDX_VAL0_HI);
          chk_in("captured", c0, c0 + 40, v);
        end
      end
    end
    // linked pair: partner control is locked and its pin released
    wr(IDX_STATUS, 8'h30);
    wr(IDX_CTL0 + 6'h1, 8'h5c);
    tick(2);
    chk("partner pin", 16'h1, 16'(ch_oe[1]));
    wr(IDX_CTL0, 8'h28);
    rd(IDX_CTL0);
    chk("leader", 16'h28, 16'(r));
    wr(IDX_CTL0 + 6'h1, 8'h50);
    rd(IDX_CTL0 + 6'h1);
    chk("partner", 16'h5c, 16'(r[6:0]));
    chk("partner pin", 16'h0, 16'(ch_oe[1]));
    finish_test();
  end
endmodule
`default_nettype wire
